// *** sel_event_host.sv ***
// Purpose: composes event log records from software fields, presents them
// Assumes: aclk 40 MHz, aresetn synchronous active low, AXI4-Lite slave
// Notes: one record at a time; refused records raise sticky error bits
// What this block does
// R1: threshold byte1[7:6] qualifies byte 2: none, reading, vendor, extension.
// R2: threshold byte1[5:4] qualifies byte 3: none, threshold, vendor, extension.
// R3: threshold byte1[3:0] carries the threshold event offset.
// R4: threshold byte 2 is the trigger reading, all ones when unspecified.
// R5: threshold byte 3 is threshold value, ones if unspecified; needs byte 2.
// R6: discrete qualifiers as threshold, but byte-3 code 01 is reserved.
// R7: discrete byte1[3:0] carries the discrete state offset.
// R8: discrete byte2[7:4] holds severity offset, 0f meaning unspecified.
// R9: discrete byte2[3:0] holds previous state offset, 0f unspecified.
// R10: discrete byte 3 is an optional vendor code, all ones if unspecified.
// R11: vendor class: byte-2 code 11 and byte-3 codes 01, 11 reserved.
// R12: vendor byte1[3:0] carries the event offset.
// R13: vendor byte2[7:4] holds vendor bits or severity, 0f unspecified.
// R14: vendor byte2[3:0] holds vendor code or previous state, 0f unspecified.
// R15: vendor byte 3 is an optional vendor code, all ones if unspecified.
// R16: the device picks the byte layout from the class of the type code.
// R17: sensor-specific type code uses the discrete layout.
// R18: type 01 threshold, 02-0c and 6f discrete, 70-7f vendor.
// R19: direction/type bit 7 is direction, bits 6:0 the type code.
// R20: reserved qualifiers or unknown type codes are flagged.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module sel_event_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [7:0] rec_dir_type,
  output logic [7:0] rec_data1,
  output logic [7:0] rec_data2,
  output logic [7:0] rec_data3
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } rec_state_t;

  rec_state_t state_q;
  logic dir_q;
  logic [6:0] type_q;
  logic [1:0] qual2_q;
  logic [1:0] qual3_q;
  logic [3:0] offset_q;
  logic [7:0] val2_q;
  logic [7:0] val3_q;
  logic send_q;
  logic rsvd_flag_q;
  logic type_flag_q;
  logic [7:0] count_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] waddr_q, raddr_q;
  logic [31:0] wdata_q;
  logic rec_valid_q;
  logic [7:0] rec_dir_type_q, rec_data1_q, rec_data2_q, rec_data3_q;
  logic [7:0] c_dir_type, c_data1, c_data2, c_data3;
  logic c_rsvd, c_type;
  logic wr_go, wr_fire, rd_go, launch, accept, refuse, st_clr_rsvd;
  logic st_clr_type;

  sel_event_compose u_compose (
    .dir(dir_q),
    .type_code(type_q),
    .qual2(qual2_q),
    .qual3(qual3_q),
    .offset(offset_q),
    .val2(val2_q),
    .val3(val3_q),
    .dir_type(c_dir_type),
    .data1(c_data1),
    .data2(c_data2),
    .data3(c_data3),
    .rsvd_err(c_rsvd),
    .type_err(c_type)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // write path: address and data are taken together in one beat
  assign wr_go = s_awvalid && s_wvalid && !awready_q && !bvalid_q;
  assign wr_fire = awready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
    end else begin
      awready_q <= wr_go;
      wready_q <= wr_go;
      if (wr_go) begin
        waddr_q <= s_awaddr;
        wdata_q <= s_wstrb[0] ? s_wdata : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= sel_event_pkg::AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (hit(waddr_q, sel_event_pkg::OFS_CTRL) ||
                  hit(waddr_q, sel_event_pkg::OFS_TYPE) ||
                  hit(waddr_q, sel_event_pkg::OFS_FIELDS) ||
                  hit(waddr_q, sel_event_pkg::OFS_BYTE2) ||
                  hit(waddr_q, sel_event_pkg::OFS_BYTE3) ||
                  hit(waddr_q, sel_event_pkg::OFS_STATUS)) ?
                 sel_event_pkg::AXI_OKAY : sel_event_pkg::AXI_SLVERR;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // only byte lane 0 is decoded: every field sits in the low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 1'b0;
      type_q <= sel_event_pkg::TYPE_THRESHOLD;
      qual2_q <= sel_event_pkg::QUAL_UNSPEC;
      qual3_q <= sel_event_pkg::QUAL_UNSPEC;
      offset_q <= 4'h0;
      val2_q <= sel_event_pkg::FILL_BYTE;
      val3_q <= sel_event_pkg::FILL_BYTE;
    end else if (wr_fire) begin
      if (hit(waddr_q, sel_event_pkg::OFS_CTRL))
        dir_q <= wdata_q[sel_event_pkg::CTRL_DIR_BIT]; // R19
      if (hit(waddr_q, sel_event_pkg::OFS_TYPE))
        type_q <= wdata_q[6:0];
      if (hit(waddr_q, sel_event_pkg::OFS_FIELDS)) begin
        qual2_q <= wdata_q[sel_event_pkg::FLD_Q2_LSB +: 2];
        qual3_q <= wdata_q[sel_event_pkg::FLD_Q3_LSB +: 2];
        offset_q <= wdata_q[sel_event_pkg::FLD_OFS_LSB +: 4];
      end
      if (hit(waddr_q, sel_event_pkg::OFS_BYTE2))
        val2_q <= wdata_q[7:0];
      if (hit(waddr_q, sel_event_pkg::OFS_BYTE3))
        val3_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      send_q <= 1'b0;
    else
      send_q <= wr_fire && hit(waddr_q, sel_event_pkg::OFS_CTRL) &&
                wdata_q[sel_event_pkg::CTRL_SEND_BIT];
  end

  // a send while a record still waits is dropped, not queued
  assign launch = send_q && (state_q == ST_IDLE);
  assign refuse = launch && (c_rsvd || c_type); // R20
  assign accept = launch && !c_rsvd && !c_type; // R16
  assign st_clr_rsvd = wr_fire && hit(waddr_q, sel_event_pkg::OFS_STATUS) &&
                       wdata_q[sel_event_pkg::ST_RSVD_BIT];
  assign st_clr_type = wr_fire && hit(waddr_q, sel_event_pkg::OFS_STATUS) &&
                       wdata_q[sel_event_pkg::ST_TYPE_BIT];

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsvd_flag_q <= 1'b0;
      type_flag_q <= 1'b0;
    end else begin
      rsvd_flag_q <= (refuse && c_rsvd) || (rsvd_flag_q && !st_clr_rsvd);
      type_flag_q <= (refuse && c_type) || (type_flag_q && !st_clr_type);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      rec_valid_q <= 1'b0;
      count_q <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_HOLD;
            rec_valid_q <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (rec_ready) begin
            state_q <= ST_IDLE;
            rec_valid_q <= 1'b0;
            count_q <= count_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          rec_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // payload is frozen while valid stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_dir_type_q <= 8'h00;
      rec_data1_q <= 8'h00;
      rec_data2_q <= sel_event_pkg::FILL_BYTE;
      rec_data3_q <= sel_event_pkg::FILL_BYTE;
    end else if (accept) begin
      rec_dir_type_q <= c_dir_type; // R19
      rec_data1_q <= c_data1; // R1 R2 R3 R6 R7 R11 R12
      rec_data2_q <= c_data2; // R4 R8 R9 R13 R14
      rec_data3_q <= c_data3; // R5 R10 R15
    end
  end

  // read data may only follow the address handshake, so the address is
  // held here and the answer is built at the edge that takes it
  assign rd_go = s_arvalid && !arready_q && !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      raddr_q <= 8'h00;
    else if (rd_go)
      raddr_q <= s_araddr;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= sel_event_pkg::AXI_OKAY;
    end else begin
      arready_q <= rd_go;
      if (arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= sel_event_pkg::AXI_OKAY;
        rdata_q <= 32'h0000_0000;
        if (hit(raddr_q, sel_event_pkg::OFS_CTRL))
          rdata_q[sel_event_pkg::CTRL_DIR_BIT] <= dir_q;
        else if (hit(raddr_q, sel_event_pkg::OFS_TYPE))
          rdata_q[6:0] <= type_q;
        else if (hit(raddr_q, sel_event_pkg::OFS_FIELDS))
          rdata_q[7:0] <= {offset_q, qual3_q, qual2_q};
        else if (hit(raddr_q, sel_event_pkg::OFS_BYTE2))
          rdata_q[7:0] <= val2_q;
        else if (hit(raddr_q, sel_event_pkg::OFS_BYTE3))
          rdata_q[7:0] <= val3_q;
        else if (hit(raddr_q, sel_event_pkg::OFS_STATUS)) begin
          rdata_q[sel_event_pkg::ST_BUSY_BIT] <= rec_valid_q;
          rdata_q[sel_event_pkg::ST_RSVD_BIT] <= rsvd_flag_q;
          rdata_q[sel_event_pkg::ST_TYPE_BIT] <= type_flag_q;
          rdata_q[sel_event_pkg::ST_CNT_LSB +: 8] <= count_q;
        end else
          rresp_q <= sel_event_pkg::AXI_SLVERR;
      end else if (rvalid_q && s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;
  assign rec_valid = rec_valid_q;
  assign rec_dir_type = rec_dir_type_q;
  assign rec_data1 = rec_data1_q;
  assign rec_data2 = rec_data2_q;
  assign rec_data3 = rec_data3_q;

  rec_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    rec_valid_q && !rec_ready |=> rec_valid_q && $stable(rec_data1_q) &&
    $stable(rec_data2_q) && $stable(rec_data3_q) &&
    $stable(rec_dir_type_q))
    else $error("record changed before it was taken");

  data1_pack_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    accept |=> rec_data1_q == {$past(qual2_q), $past(qual3_q),
    $past(offset_q)})
    else $error("data byte 1 does not match qualifiers and offset");

  byte2_fill_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    accept && qual2_q == sel_event_pkg::QUAL_UNSPEC
    |=> rec_data2_q == sel_event_pkg::FILL_BYTE)
    else $error("unspecified byte 2 not filled with ones");

  byte3_fill_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    accept && qual3_q == sel_event_pkg::QUAL_UNSPEC
    |=> rec_data3_q == sel_event_pkg::FILL_BYTE)
    else $error("unspecified byte 3 not filled with ones");

  discrete_rsvd_a: assert property (@(posedge aclk) // R6
    disable iff (!aresetn)
    launch && sel_event_pkg::class_of(type_q) ==
    sel_event_pkg::CLS_DISCRETE && qual3_q == sel_event_pkg::QUAL_PRIMARY
    |=> !rec_valid_q && rsvd_flag_q)
    else $error("discrete record with reserved byte 3 code was sent");

  vendor_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    launch && sel_event_pkg::class_of(type_q) == sel_event_pkg::CLS_VENDOR
    && qual2_q == sel_event_pkg::QUAL_EXT |=> !rec_valid_q && rsvd_flag_q)
    else $error("vendor record with reserved byte 2 code was sent");

  type_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    launch && sel_event_pkg::class_of(type_q) == sel_event_pkg::CLS_NONE
    |=> !rec_valid_q && type_flag_q ##1 type_flag_q || $past(st_clr_type))
    else $error("unknown type code not flagged");

  sensor_spec_a: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    launch && type_q == sel_event_pkg::TYPE_SENSOR_SPEC &&
    qual3_q != sel_event_pkg::QUAL_PRIMARY |=> rec_valid_q)
    else $error("sensor-specific record not sent with discrete layout");

  dir_bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    accept |=> rec_dir_type_q == {$past(dir_q), $past(type_q)})
    else $error("direction or type code misplaced");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_awready ##1 s_bvalid)
    else $error("write response not two cycles after acceptance");

  threshold_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    accept && type_q == sel_event_pkg::TYPE_THRESHOLD ##[1:20] rec_ready);
  vendor_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    accept && sel_event_pkg::class_of(type_q) == sel_event_pkg::CLS_VENDOR);
  refuse_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    refuse ##[1:30] st_clr_rsvd);

endmodule

// *** sel_event_pkg.sv ***
// Purpose: constants shared by the event record composer and its top
// Assumes: one 40 MHz clock, 32-bit register words
// Notes: register offsets are byte addresses on the register bus
package sel_event_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TYPE = 8'h04;
  localparam logic [7:0] OFS_FIELDS = 8'h08;
  localparam logic [7:0] OFS_BYTE2 = 8'h0c;
  localparam logic [7:0] OFS_BYTE3 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam int CTRL_SEND_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RSVD_BIT = 1;
  localparam int ST_TYPE_BIT = 2;
  localparam int ST_CNT_LSB = 8;
  localparam int FLD_Q2_LSB = 0;
  localparam int FLD_Q3_LSB = 2;
  localparam int FLD_OFS_LSB = 4;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  localparam logic [6:0] TYPE_THRESHOLD = 7'h01;
  localparam logic [6:0] TYPE_GENERIC_LO = 7'h02;
  localparam logic [6:0] TYPE_GENERIC_HI = 7'h0c;
  localparam logic [6:0] TYPE_SENSOR_SPEC = 7'h6f;
  localparam logic [6:0] TYPE_VENDOR_LO = 7'h70;
  localparam logic [6:0] TYPE_VENDOR_HI = 7'h7f;

  localparam logic [1:0] QUAL_UNSPEC = 2'h0;
  localparam logic [1:0] QUAL_PRIMARY = 2'h1;
  localparam logic [1:0] QUAL_VENDOR = 2'h2;
  localparam logic [1:0] QUAL_EXT = 2'h3;

  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [3:0] FILL_NIBBLE = 4'hf;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h1,
    CLS_THRESHOLD = 4'h2,
    CLS_DISCRETE = 4'h4,
    CLS_VENDOR = 4'h8
  } class_t;

  // the sensor-specific code shares the discrete layout
  function automatic class_t class_of(input logic [6:0] code);
    if (code == TYPE_THRESHOLD)
      return CLS_THRESHOLD;
    else if ((code >= TYPE_GENERIC_LO && code <= TYPE_GENERIC_HI) ||
             code == TYPE_SENSOR_SPEC)
      return CLS_DISCRETE;
    else if (code >= TYPE_VENDOR_LO && code <= TYPE_VENDOR_HI)
      return CLS_VENDOR;
    else
      return CLS_NONE;
  endfunction

endpackage

// *** sel_event_compose.sv ***
// Purpose: builds direction/type byte and data bytes 1 to 3 of a record
// Assumes: inputs stable while the caller samples the outputs
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module sel_event_compose (
  input wire logic dir,
  input wire logic [6:0] type_code,
  input wire logic [1:0] qual2,
  input wire logic [1:0] qual3,
  input wire logic [3:0] offset,
  input wire logic [7:0] val2,
  input wire logic [7:0] val3,
  output logic [7:0] dir_type,
  output logic [7:0] data1,
  output logic [7:0] data2,
  output logic [7:0] data3,
  output logic rsvd_err,
  output logic type_err
);

  sel_event_pkg::class_t cls;

  always_comb begin
    cls = sel_event_pkg::class_of(type_code); // R17 R18
    dir_type = {dir, type_code};
    data1 = {qual2, qual3, offset};
    type_err = (cls == sel_event_pkg::CLS_NONE);
    rsvd_err = 1'b0;
    unique case (cls)
      sel_event_pkg::CLS_DISCRETE: begin
        rsvd_err = (qual3 == sel_event_pkg::QUAL_PRIMARY);
      end
      sel_event_pkg::CLS_VENDOR: begin
        rsvd_err = (qual2 == sel_event_pkg::QUAL_EXT) ||
                   (qual3 == sel_event_pkg::QUAL_PRIMARY) ||
                   (qual3 == sel_event_pkg::QUAL_EXT);
      end
      sel_event_pkg::CLS_THRESHOLD, sel_event_pkg::CLS_NONE: begin
        rsvd_err = 1'b0;
      end
    endcase
    // byte 2 always sent, so a present byte 3 never lacks byte 2
    data2 = val2;
    data3 = val3;
    if (qual2 == sel_event_pkg::QUAL_UNSPEC)
      data2 = sel_event_pkg::FILL_BYTE;
    else if (qual2 == sel_event_pkg::QUAL_PRIMARY &&
             cls != sel_event_pkg::CLS_THRESHOLD) begin
      // nibbles are severity and previous state; software puts 0f in one
      // to leave it unspecified
      data2 = {val2[7:4], val2[3:0]};
    end
    if (qual3 == sel_event_pkg::QUAL_UNSPEC)
      data3 = sel_event_pkg::FILL_BYTE;
  end

endmodule

// *** sel_event_sink.sv ***
// Purpose: record consumer standing on the far side of the record link
// Assumes: rec_ready changes only after a rising edge of aclk
// Notes: stall holds ready low so the sender must keep the record steady
`timescale 1ns/1ps
module sel_event_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire logic rec_valid,
  output logic rec_ready,
  input wire logic [7:0] rec_dir_type,
  input wire logic [7:0] rec_data1,
  input wire logic [7:0] rec_data2,
  input wire logic [7:0] rec_data3,
  output logic [7:0] got_dir_type,
  output logic [7:0] got_data1,
  output logic [7:0] got_data2,
  output logic [7:0] got_data3,
  output logic [15:0] take_cnt,
  output logic [15:0] bad_cnt
);
  logic [6:0] code;
  logic [1:0] cls;
  logic [1:0] q2;
  logic [1:0] q3;
  logic bad;
  assign code = rec_dir_type[6:0];
  assign q2 = rec_data1[7:6];
  assign q3 = rec_data1[5:4];
  // 1 threshold, 2 discrete, 3 vendor, 0 unknown
  always_comb begin
    if (code == 7'h01)
      cls = 2'h1;
    else if ((code >= 7'h02 && code <= 7'h0c) || code == 7'h6f)
      cls = 2'h2;
    else if (code >= 7'h70)
      cls = 2'h3;
    else
      cls = 2'h0;
  end
  always_comb begin
    // byte 2 stays on the link, filled with ones if unspecified, whenever byte 3 is sent
    bad = (cls == 2'h0)
      || (q3 != 2'h0 && q2 == 2'h0 && rec_data2 != 8'hff)
      || (q2 == 2'h0 && rec_data2 != 8'hff)
      || (q3 == 2'h0 && rec_data3 != 8'hff)
      || (cls == 2'h2 && q3 == 2'h1)
      || (cls == 2'h3 && (q2 == 2'h3 || q3[0]));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rec_ready <= 1'b0;
    else
      rec_ready <= !stall;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      take_cnt <= 16'h0000;
      bad_cnt <= 16'h0000;
    end else if (rec_valid && rec_ready) begin
      take_cnt <= take_cnt + 16'h0001;
      bad_cnt <= bad_cnt + {15'h0000, bad};
      got_dir_type <= rec_dir_type;
      got_data1 <= rec_data1;
      got_data2 <= rec_data2;
      got_data3 <= rec_data3;
    end
  end
endmodule

// *** sel_event_host_tb_top.sv ***
// Purpose: self-checking bench for the event record composer
// Assumes: aclk 40 MHz, aresetn held low for 3 cycles at start
// Notes: each register task begins one edge after the previous one ended
`timescale 1ns/1ps
module sel_event_host_tb_top;
  logic aclk, aresetn, stall;
  logic [7:0] s_awaddr, s_araddr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic [31:0] s_wdata, s_rdata, st;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_arvalid, s_arready, s_rvalid, s_rready, rec_valid, rec_ready;
  logic [7:0] rec_dir_type, rec_data1, rec_data2, rec_data3;
  logic [7:0] got_dir_type, got_data1, got_data2, got_data3;
  logic [15:0] take_cnt, bad_cnt, n0;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int exp_cnt = 0;
  // record codes covering every class edge, sensor-specific included
  logic [6:0] codes [6] = '{7'h01, 7'h02, 7'h0c, 7'h6f, 7'h70, 7'h7f};
  logic [7:0] rst_ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rst_val [6] = '{0, 32'h01, 0, 32'hff, 32'hff, 0};

  sel_event_host dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_dir_type(rec_dir_type),
    .rec_data1(rec_data1), .rec_data2(rec_data2), .rec_data3(rec_data3));
  sel_event_sink sink_u (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_dir_type(rec_dir_type), .rec_data1(rec_data1),
    .rec_data2(rec_data2), .rec_data3(rec_data3),
    .got_dir_type(got_dir_type), .got_data1(got_data1),
    .got_data2(got_data2), .got_data3(got_data3), .take_cnt(take_cnt),
    .bad_cnt(bad_cnt));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // generous ceiling: about 100 records at roughly 30 cycles each
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    check(s_bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
                        output logic [31:0] d);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    d = s_rdata;
    check(s_rresp, er);
  endtask

  task automatic setup(input logic [6:0] code, input logic [1:0] q2,
      input logic [1:0] q3, input logic [3:0] ofs, input logic [7:0] b2,
      input logic [7:0] b3);
    axi_wr(sel_event_pkg::OFS_TYPE, {25'h0, code}, sel_event_pkg::AXI_OKAY);
    axi_wr(sel_event_pkg::OFS_FIELDS, {24'h0, ofs, q3, q2},
           sel_event_pkg::AXI_OKAY);
    axi_wr(sel_event_pkg::OFS_BYTE2, {24'h0, b2}, sel_event_pkg::AXI_OKAY);
    axi_wr(sel_event_pkg::OFS_BYTE3, {24'h0, b3}, sel_event_pkg::AXI_OKAY);
  endtask

  task automatic run(input logic dir, input logic [6:0] code,
      input logic [1:0] q2, input logic [1:0] q3, input logic [3:0] ofs,
      input logic [7:0] b2, input logic [7:0] b3);
    logic none, disc, vend, rsv;
    none = !(code == 7'h01 || (code >= 7'h02 && code <= 7'h0c) ||
             code == 7'h6f || code >= 7'h70);
    disc = (code >= 7'h02 && code <= 7'h0c) || code == 7'h6f;
    vend = code >= 7'h70;
    rsv = (disc && q3 == 2'h1) || (vend && (q2 == 2'h3 || q3[0]));
    n0 = take_cnt;
    setup(code, q2, q3, ofs, b2, b3);
    axi_wr(sel_event_pkg::OFS_CTRL, {30'h0, dir, 1'b1},
           sel_event_pkg::AXI_OKAY);
    if (!none && !rsv) begin
      while (take_cnt == n0) @(posedge aclk);
      exp_cnt++;
      check(got_dir_type, {dir, code});
      check(got_data1, {q2, q3, ofs});
      check(got_data2, q2 == 2'h0 ? 8'hff : b2);
      check(got_data3, q3 == 2'h0 ? 8'hff : b3);
    end else begin
      // the record would appear two cycles after the handshake
      repeat (6) @(posedge aclk);
      check(take_cnt, n0);
      axi_rd(sel_event_pkg::OFS_STATUS, sel_event_pkg::AXI_OKAY, st);
      check(st[2:1], {none, rsv});
      axi_wr(sel_event_pkg::OFS_STATUS, 32'h6, sel_event_pkg::AXI_OKAY);
    end
  endtask

  initial begin
    aresetn = 1'b0;
    stall = 1'b0;
    s_awaddr = 8'h00;
    s_awvalid = 1'b0;
    s_wdata = 32'h0;
    s_wstrb = 4'hf;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = 8'h00;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check(rec_valid, 1'b0);
    check(rec_data2, 8'hff);
    for (int i = 0; i < 6; i++) begin
      axi_rd(rst_ofs[i], sel_event_pkg::AXI_OKAY, st);
      check(st, rst_val[i]);
    end
    // unmapped place answers with an error and zero data
    axi_wr(8'h18, 32'h1, sel_event_pkg::AXI_SLVERR);
    axi_rd(8'h18, sel_event_pkg::AXI_SLVERR, st);
    check(st, 32'h0);
    // a write without byte lane 0 stores zeros
    s_wstrb <= 4'he;
    axi_wr(sel_event_pkg::OFS_BYTE2, 32'h5a, sel_event_pkg::AXI_OKAY);
    s_wstrb <= 4'hf;
    axi_rd(sel_event_pkg::OFS_BYTE2, sel_event_pkg::AXI_OKAY, st);
    check(st, 32'h0);
    // every qualifier pair on every known class (threshold, discrete, vendor), reserved pairs included
    for (int c = 0; c < 6; c++) begin
      for (int i = 0; i < 16; i++) begin
        run(i[0], codes[c], i[3:2], i[1:0], 4'(i * 5 + c),
            {4'(i), 4'hf}, 8'h5a ^ 8'(i));
      end
    end
    run(1'b0, 7'h00, 2'h0, 2'h0, 4'h1, 8'h11, 8'h22);
    run(1'b1, 7'h0d, 2'h0, 2'h0, 4'h2, 8'h11, 8'h22);
    run(1'b0, 7'h6e, 2'h0, 2'h0, 4'h3, 8'h11, 8'h22);
    // stalled far side: record must hold and a second send is dropped
    stall <= 1'b1;
    n0 = take_cnt;
    setup(7'h07, 2'h1, 2'h2, 4'h9, 8'h3f, 8'h77);
    axi_wr(sel_event_pkg::OFS_CTRL, 32'h1, sel_event_pkg::AXI_OKAY);
    repeat (4) @(posedge aclk);
    check(rec_valid, 1'b1);
    axi_rd(sel_event_pkg::OFS_STATUS, sel_event_pkg::AXI_OKAY, st);
    check(st[0], 1'b1);
    setup(7'h01, 2'h2, 2'h1, 4'h4, 8'h12, 8'h34);
    axi_wr(sel_event_pkg::OFS_CTRL, 32'h3, sel_event_pkg::AXI_OKAY);
    repeat (4) @(posedge aclk);
    check(rec_data1, 8'h69);
    stall <= 1'b0;
    while (take_cnt == n0) @(posedge aclk);
    exp_cnt++;
    check(got_dir_type, 8'h07);
    check(got_data2, 8'h3f);
    check(got_data3, 8'h77);
    repeat (6) @(posedge aclk);
    check(take_cnt, n0 + 16'h1);
    axi_rd(sel_event_pkg::OFS_STATUS, sel_event_pkg::AXI_OKAY, st);
    check(st[15:8], 8'(exp_cnt));
    check(bad_cnt, 16'h0);
    print_verdict();
  end
endmodule
